// ===== core/cgo_clk_sync.sv
// Two-flop sampler for a foreign clock pin, with rising edge pulse.
// Assumes the pin toggles below half the core clock rate.
`timescale 1ns/10ps
`default_nettype none
module cgo_clk_sync
	import cgo_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst_n,
	// Foreign clock pin
	input  wire logic clkPin,
	// Sampled view
	output var  cgo_edge_s sampled
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} cgo_sync_s;

	cgo_sync_s s_r;
	cgo_sync_s s_nxt;

	// Shift chain; the second stage gives the level, the second and third give the edge
	always_comb
	begin
		s_nxt.s1 = clkPin;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Edge pulse from the settled stages
	assign sampled = '{lvl: s_r.s2, rise: s_r.s2 & ~s_r.s3};

endmodule : cgo_clk_sync
`default_nettype wire

// ===== core/cgo_clock_gating.sv
// Clock gates, programmable clock outputs, master clock selection,
// oscillator start-up, frequency measure and PLL settle sequencing.
// Assumes slow, main and PLL clocks arrive on pins well below core_clk/2.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Peripheral gates set, cleared and read back singly.
// - Cleared gate stops its clock at once; gates off at reset.
// - Gate bit number equals peripheral identifier.
// - Four outputs, each separately configured.
// - Output source slow, PLL or main; slow by default.
// - Output divides by powers of two, 1 to 64; 1 by default.
// - A 1 in set or clear turns an output on or off; state readable.
// - Ready flag per output once it runs as programmed.
// - No glitch guard on live output reconfiguration.
// - Oscillator enable: stable flag after eight times count slow cycles.
// - Interrupt follows enabled stable, lock, master or output ready flags.
// - Count main cycles over sixteen slow cycles, then flag done.
// - PLL divide 0 to 255; zero, the default, turns it off.
// - PLL factor 0 to 2047; zero turns PLL off.
// - PLL write counts settle slow cycles before lock flag.
// - PLL rewrite clears lock until relock.
// - USB clock is PLL output divided by 1, 2 or 4.
// - Master is source over 1 to 64, slow undivided default; cpu follows.
// - Master change clears master ready until clocks settle.
// - PLL master source falls back to main while unlocked.
// - Start-up count runs on slow clock over eight; stable clears at start.
// - Zero bits in set or clear writes leave gates untouched.
module cgo_clock_gating
	import cgo_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Clock pins from the oscillators and PLL
	input  wire logic                 slowClkPin,
	input  wire logic                 mainClkPin,
	input  wire logic                 pllClkPin,
	// Register writes, one strobe per register, shared data
	input  wire logic [WORD_W-1:0]    wrData,
	input  wire logic                 periphSetWr,
	input  wire logic                 periphClrWr,
	input  wire logic                 sysSetWr,
	input  wire logic                 sysClrWr,
	input  wire logic                 outCfgWr,
	input  wire logic [OUT_SEL_W-1:0] outCfgSel,
	input  wire logic                 oscCtrlWr,
	input  wire logic                 pllCfgWr,
	input  wire logic                 mckCfgWr,
	input  wire logic                 irqEnWr,
	input  wire logic                 irqDisWr,
	// Register reads
	output logic [WORD_W-1:0]         periphGateState,
	output logic [WORD_W-1:0]         sysClkState,
	output logic [WORD_W-1:0]         pmStatus,
	output logic [WORD_W-1:0]         freqMeasure,
	output logic [WORD_W-1:0]         irqMaskState,
	// Analog controls
	output logic                      oscEnable,
	output logic                      pllEnable,
	output logic [PLL_DIV_W-1:0]      pllDivRatio,
	output logic [PLL_MUL_W-1:0]      pllFactor,
	// Clocks out and interrupt
	output logic [PERIPH_W-1:0]       periphClk,
	output logic [NUM_OUT-1:0]        outclkPin,
	output logic                      masterClk,
	output logic                      cpuClk,
	output logic                      usbClk,
	output logic                      irq
);

	typedef struct packed {
		logic [PERIPH_W-1:0]       periphGate;
		logic [SYS_W-1:0]          sysGate;
		cgo_clkcfg_s [NUM_OUT-1:0] outCfg;
		logic [NUM_OUT-1:0]        outRdy;
		logic                      oscEn;
		logic [OSC_CNT_W-1:0]      oscCnt;
		logic [2:0]                slow8;
		logic                      oscStable;
		logic                      measArm;
		logic                      measRun;
		logic [3:0]                measSlow;
		logic [FREQ_W-1:0]         mainCnt;
		logic                      measDone;
		logic [PLL_DIV_W-1:0]      pllDiv;
		logic [PLL_MUL_W-1:0]      pllMul;
		logic [PLL_CNT_W-1:0]      pllCnt;
		logic [PLL_USB_W-1:0]      usbRatio;
		logic                      pllOn;
		logic                      lock;
		cgo_clkcfg_s               mckCfg;
		logic                      mRdy;
		logic [WORD_W-1:0]         irqMask;
		logic [PERIPH_W-1:0]       pClk;
		logic [NUM_OUT-1:0]        oPin;
		logic                      mClk;
		logic                      cClk;
		logic                      uClk;
		logic                      irqOut;
	} cgo_state_s;

	cgo_state_s s_r;
	cgo_state_s s_nxt;

	cgo_edge_s                 slowE;
	cgo_edge_s                 mainE;
	cgo_edge_s                 pllRawE;
	cgo_edge_s                 pllE;
	cgo_edge_s [NUM_OUT-1:0]   outSrc;
	cgo_edge_s                 mckSrc;
	logic [NUM_OUT-1:0]        outRestart;
	logic [NUM_OUT-1:0]        presOut;
	logic [NUM_OUT-1:0]        presRise;
	logic                      mckRestart;
	logic                      mckOut;
	logic                      mckRise;
	logic                      usbRestart;
	logic                      usbOut;
	logic [RATIO_W-1:0]        usbRatio3;
	logic                      slow8Tick;
	logic                      mckPll;
	logic                      outHit;
	logic [WORD_W-1:0]         statusW;

	// Source mux shared by outputs and master; unknown codes pick slow
	function automatic cgo_edge_s pickSrc(input logic [1:0] src, input cgo_edge_s sl,
		input cgo_edge_s mn, input cgo_edge_s pl);
		cgo_edge_s e;
		e = sl;
		if (src == SRC_MAIN)
			e = mn;
		else if (src == SRC_PLL)
			e = pl;
		return e;
	endfunction : pickSrc

	// Foreign clocks pass two flops before use
	cgo_clk_sync u_slowSync (.core_clk(core_clk), .rst_n(rst_n), .clkPin(slowClkPin),
		.sampled(slowE));
	cgo_clk_sync u_mainSync (.core_clk(core_clk), .rst_n(rst_n), .clkPin(mainClkPin),
		.sampled(mainE));
	cgo_clk_sync u_pllSync (.core_clk(core_clk), .rst_n(rst_n), .clkPin(pllClkPin),
		.sampled(pllRawE));

	// Programmable output dividers
	for (genvar g = 0; g < NUM_OUT; g++)
	begin : g_out
		cgo_prescaler u_clk_ratio_sel (.core_clk(core_clk), .rst_n(rst_n), .src(outSrc[g]),
			.ratio(s_r.outCfg[g].ratio), .restart(outRestart[g]),
			.clkOut(presOut[g]), .outRise(presRise[g]));
	end

	// Master and USB dividers
	cgo_prescaler u_mckPres (.core_clk(core_clk), .rst_n(rst_n), .src(mckSrc),
		.ratio(s_r.mckCfg.ratio), .restart(mckRestart), .clkOut(mckOut),
		.outRise(mckRise));
	cgo_prescaler u_usbPres (.core_clk(core_clk), .rst_n(rst_n), .src(pllE),
		.ratio(usbRatio3), .restart(usbRestart), .clkOut(usbOut), .outRise());

	// Status word from flag flops
	always_comb
	begin
		statusW = '0;
		statusW[ST_OSC_BIT]  = s_r.oscStable;
		statusW[ST_LOCK_BIT] = s_r.lock;
		statusW[ST_MRDY_BIT] = s_r.mRdy;
		statusW[ST_ORDY_LSB +: NUM_OUT] = s_r.outRdy;
	end

	// Next state of the whole block
	always_comb
	begin
		s_nxt = s_r;
		// PLL output is a flat zero while off
		pllE = s_r.pllOn ? pllRawE : '0;

		// Gates: only ones act, clear beats set on the same bit
		if (periphSetWr)
			s_nxt.periphGate = s_r.periphGate | wrData;
		if (periphClrWr)
			s_nxt.periphGate = s_nxt.periphGate & ~wrData;
		if (sysSetWr)
			s_nxt.sysGate = s_r.sysGate | wrData[SYS_W-1:0];
		if (sysClrWr)
			s_nxt.sysGate = s_nxt.sysGate & ~wrData[SYS_W-1:0];

		// Oscillator start-up on slow clock over eight
		slow8Tick = slowE.rise && (s_r.slow8 == SLOW8_LAST);
		if (slowE.rise)
			s_nxt.slow8 = s_r.slow8 + 3'h1;
		if (oscCtrlWr)
		begin
			s_nxt.oscEn     = wrData[OSC_EN_BIT];
			s_nxt.oscCnt    = wrData[OSC_CNT_LSB +: OSC_CNT_W];
			s_nxt.oscStable = 1'b0;
			s_nxt.slow8     = '0;
		end
		else if (s_r.oscEn && !s_r.oscStable && slow8Tick)
		begin
			// Last tick sets the flag so a count of N gives 8*N slow cycles
			if (s_r.oscCnt <= 8'h01)
			begin
				s_nxt.oscStable = 1'b1;
				s_nxt.oscCnt    = '0;
			end
			else
				s_nxt.oscCnt = s_r.oscCnt - 8'h01;
		end

		// Frequency measure starts at the slow edge after stable
		if (s_nxt.oscStable && !s_r.oscStable)
		begin
			s_nxt.measArm  = 1'b1;
			s_nxt.measRun  = 1'b0;
			s_nxt.measDone = 1'b0;
			s_nxt.mainCnt  = '0;
		end
		else if (s_r.measArm && slowE.rise)
		begin
			s_nxt.measArm  = 1'b0;
			s_nxt.measRun  = 1'b1;
			s_nxt.measSlow = '0;
		end
		else if (s_r.measRun)
		begin
			if (mainE.rise)
				s_nxt.mainCnt = s_r.mainCnt + 16'h1;
			if (slowE.rise)
			begin
				s_nxt.measSlow = s_r.measSlow + 4'h1;
				if (s_r.measSlow == MEAS_LAST)
				begin
					s_nxt.measRun  = 1'b0;
					s_nxt.measDone = 1'b1;
				end
			end
		end
		// Losing the oscillator aborts a measure in flight
		if (!s_nxt.oscStable)
		begin
			s_nxt.measArm = 1'b0;
			s_nxt.measRun = 1'b0;
		end

		// PLL: every write reloads the settle count and drops lock
		if (pllCfgWr)
		begin
			s_nxt.pllDiv   = wrData[PLL_DIV_LSB +: PLL_DIV_W];
			s_nxt.pllMul   = wrData[PLL_MUL_LSB +: PLL_MUL_W];
			s_nxt.pllCnt   = wrData[PLL_CNT_LSB +: PLL_CNT_W];
			s_nxt.usbRatio = wrData[PLL_USB_LSB +: PLL_USB_W];
			s_nxt.pllOn    = (s_nxt.pllDiv != '0) && (s_nxt.pllMul != '0);
			s_nxt.lock     = 1'b0;
		end
		else if (s_r.pllOn && !s_r.lock && slowE.rise)
		begin
			if (s_r.pllCnt <= 6'h01)
			begin
				s_nxt.lock   = 1'b1;
				s_nxt.pllCnt = '0;
			end
			else
				s_nxt.pllCnt = s_r.pllCnt - 6'h01;
		end

		// Master clock; PLL source falls back to main while unlocked
		if (mckCfgWr)
			s_nxt.mckCfg = cfgOf(wrData);
		mckPll     = (s_r.mckCfg.src == SRC_PLL);
		mckRestart = mckCfgWr || (mckPll && (s_nxt.lock != s_r.lock));
		mckSrc     = pickSrc((mckPll && !s_r.lock) ? SRC_MAIN : s_r.mckCfg.src,
			slowE, mainE, pllE);
		if (mckRestart)
			s_nxt.mRdy = 1'b0;
		else if (mckRise && (!mckPll || s_r.lock))
			s_nxt.mRdy = 1'b1;

		// Programmable outputs; no glitch guard on live reconfiguration
		for (int i = 0; i < NUM_OUT; i++)
		begin
			outHit = outCfgWr && (outCfgSel == OUT_SEL_W'(i));
			if (outHit)
				s_nxt.outCfg[i] = cfgOf(wrData);
			outSrc[i]     = pickSrc(s_r.outCfg[i].src, slowE, mainE, pllE);
			outRestart[i] = outHit || !s_nxt.sysGate[SYS_OUT_LSB + i];
			if (outRestart[i])
				s_nxt.outRdy[i] = 1'b0;
			else if (presRise[i])
				s_nxt.outRdy[i] = 1'b1;
			s_nxt.oPin[i] = presOut[i] & s_r.sysGate[SYS_OUT_LSB + i];
		end

		// USB divide code 3 is treated as divide by four
		usbRestart = !s_nxt.sysGate[SYS_USB_BIT];
		usbRatio3  = (s_r.usbRatio > 2'h2) ? 3'h2 : {1'b0, s_r.usbRatio};
		s_nxt.uClk = usbOut & s_r.sysGate[SYS_USB_BIT];

		// Clock outputs; a cleared gate drops its clock on this same edge
		s_nxt.pClk = {PERIPH_W{mckOut}} & s_nxt.periphGate;
		s_nxt.mClk = mckOut;
		s_nxt.cClk = mckOut & s_nxt.sysGate[SYS_CPU_BIT];

		// Interrupt: level of enabled flags
		if (irqEnWr)
			s_nxt.irqMask = s_r.irqMask | wrData;
		if (irqDisWr)
			s_nxt.irqMask = s_nxt.irqMask & ~wrData;
		s_nxt.irqOut = |(statusW & s_r.irqMask);
	end

	// Reset: gates off except cpu, master on slow undivided and ready
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_r         <= '0;
			s_r.sysGate <= SYS_RST;
			s_r.mRdy    <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	// Read-back and outputs, all from flops
	assign periphGateState = s_r.periphGate;
	assign sysClkState     = {{(WORD_W-SYS_W){1'b0}}, s_r.sysGate};
	assign pmStatus        = statusW;
	assign freqMeasure     = {{(WORD_W-FREQ_W-1){1'b0}}, s_r.measDone, s_r.mainCnt};
	assign irqMaskState    = s_r.irqMask;
	assign oscEnable       = s_r.oscEn;
	assign pllEnable       = s_r.pllOn;
	assign pllDivRatio     = s_r.pllDiv;
	assign pllFactor       = s_r.pllMul;
	assign periphClk       = s_r.pClk;
	assign outclkPin       = s_r.oPin;
	assign masterClk       = s_r.mClk;
	assign cpuClk          = s_r.cClk;
	assign usbClk          = s_r.uClk;
	assign irq             = s_r.irqOut;

endmodule : cgo_clock_gating
`default_nettype wire

// ===== core/cgo_pkg.sv
// Constants, field layouts and carrier types of the clock gating block.
// Assumes one core clock; all other clocks arrive as sampled pins.
package cgo_pkg;

	// Sizes
	localparam int NUM_OUT   = 4;
	localparam int OUT_SEL_W = 2;
	localparam int PERIPH_W  = 32;
	localparam int SYS_W     = 12;
	localparam int WORD_W    = 32;

	// Source select codes
	localparam logic [1:0] SRC_SLOW = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_PLL  = 2'h3;

	// Output and master configuration word
	localparam int CFG_SRC_LSB   = 0;
	localparam int CFG_RATIO_LSB = 2;
	localparam int RATIO_W       = 3;

	// Oscillator control word
	localparam int OSC_EN_BIT  = 0;
	localparam int OSC_CNT_LSB = 8;
	localparam int OSC_CNT_W   = 8;

	// PLL configuration word
	localparam int PLL_DIV_LSB = 0;
	localparam int PLL_DIV_W   = 8;
	localparam int PLL_CNT_LSB = 8;
	localparam int PLL_CNT_W   = 6;
	localparam int PLL_MUL_LSB = 16;
	localparam int PLL_MUL_W   = 11;
	localparam int PLL_USB_LSB = 28;
	localparam int PLL_USB_W   = 2;

	// System clock gate bits
	localparam int SYS_CPU_BIT = 0;
	localparam int SYS_USB_BIT = 7;
	localparam int SYS_OUT_LSB = 8;
	localparam logic [SYS_W-1:0] SYS_RST = 12'h001;

	// Status word bits
	localparam int ST_OSC_BIT   = 0;
	localparam int ST_LOCK_BIT  = 2;
	localparam int ST_MRDY_BIT  = 3;
	localparam int ST_ORDY_LSB  = 8;

	// Frequency word
	localparam int FREQ_W        = 16;
	localparam int FREQ_DONE_BIT = 16;

	// Timing counts in slow clock cycles
	localparam logic [2:0] SLOW8_LAST = 3'h7;
	localparam logic [3:0] MEAS_LAST  = 4'hf;

	// A sampled clock: level and one-cycle rising pulse
	typedef struct packed {
		logic lvl;
		logic rise;
	} cgo_edge_s;

	// Source and ratio of a divided clock
	typedef struct packed {
		logic [1:0]         src;
		logic [RATIO_W-1:0] ratio;
	} cgo_clkcfg_s;

	// Half-period count minus one for divide by 2**ratio; ratios 6 and 7 both give 64
	function automatic logic [4:0] halfLimit(input logic [RATIO_W-1:0] ratio);
		logic [4:0] lim;
		lim = 5'h1f;
		if (ratio < 3'h6)
			lim = 5'((6'h1 << ratio) >> 1) - 5'h1;
		return lim;
	endfunction : halfLimit

	// Configuration word to source and ratio
	function automatic cgo_clkcfg_s cfgOf(input logic [WORD_W-1:0] w);
		cgo_clkcfg_s c;
		c.src   = w[CFG_SRC_LSB +: 2];
		c.ratio = w[CFG_RATIO_LSB +: RATIO_W];
		return c;
	endfunction : cfgOf

endpackage : cgo_pkg

// ===== core/cgo_prescaler.sv
// Power-of-two prescaler running on rising-edge pulses of a source.
// Assumes source pulses are one core cycle wide.
`timescale 1ns/10ps
`default_nettype none
module cgo_prescaler
	import cgo_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// Source and control
	input  wire cgo_edge_s          src,
	input  wire logic [RATIO_W-1:0] ratio,
	input  wire logic               restart,
	// Divided clock
	output var  logic               clkOut,
	output var  logic               outRise
);

	typedef struct packed {
		logic [4:0] cnt;
		logic       out;
		logic       rise;
	} cgo_clk_ratio_sel_s;

	cgo_clk_ratio_sel_s s_r;
	cgo_clk_ratio_sel_s s_nxt;

	// Divide by one follows the source; otherwise toggle per half period
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.rise = 1'b0;
		if (restart)
		begin
			s_nxt.cnt = '0;
			s_nxt.out = 1'b0;
		end
		else if (ratio == '0)
		begin
			s_nxt.out  = src.lvl;
			s_nxt.rise = src.lvl & ~s_r.out;
		end
		else if (src.rise)
		begin
			if (s_r.cnt == halfLimit(ratio))
			begin
				s_nxt.cnt  = '0;
				s_nxt.out  = ~s_r.out;
				s_nxt.rise = ~s_r.out;
			end
			else
				s_nxt.cnt = s_r.cnt + 5'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign clkOut  = s_r.out;
	assign outRise = s_r.rise;

endmodule : cgo_prescaler
`default_nettype wire

// ===== dv/cgo_clock_gating_props.sv
// Port-level checks of the clock gating block.
// Assumes a bind onto cgo_clock_gating; one core clock domain.
`timescale 1ns/10ps
`default_nettype none
module cgo_clock_gating_props
	import cgo_pkg::*;
(
	// Clock and reset
	input wire logic                core_clk,
	input wire logic                rst_n,
	// Writes
	input wire logic [WORD_W-1:0]   wrData,
	input wire logic                periphSetWr,
	input wire logic                periphClrWr,
	input wire logic                sysSetWr,
	input wire logic                sysClrWr,
	input wire logic                oscCtrlWr,
	input wire logic                pllCfgWr,
	input wire logic                mckCfgWr,
	// Observed outputs
	input wire logic [WORD_W-1:0]   periphGateState,
	input wire logic [WORD_W-1:0]   sysClkState,
	input wire logic [WORD_W-1:0]   pmStatus,
	input wire logic [WORD_W-1:0]   irqMaskState,
	input wire logic                pllEnable,
	input wire logic [PLL_DIV_W-1:0] pllDivRatio,
	input wire logic [PLL_MUL_W-1:0] pllFactor,
	input wire logic [PERIPH_W-1:0] periphClk,
	input wire logic                irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	// Flag drops in the cycle after the write
	sequence s_mckDown;
		##1 !pmStatus[ST_MRDY_BIT];
	endsequence
	sequence s_lockDown;
		##1 !pmStatus[ST_LOCK_BIT];
	endsequence

	// Peripheral gates
	property p_gateStop;
		periphClrWr |=> ((periphClk & $past(wrData)) == '0);
	endproperty
	a_gateStop: assert property (p_gateStop) else $error("cleared gate runs");
	property p_gateSet;
		(periphSetWr && !periphClrWr) |=> ((periphGateState & $past(wrData)) == $past(wrData));
	endproperty
	a_gateSet: assert property (p_gateSet) else $error("gate set not taken");
	property p_gateZero;
		(periphSetWr && !periphClrWr)
			|=> (((periphGateState ^ $past(periphGateState)) & ~$past(wrData)) == '0);
	endproperty
	a_gateZero: assert property (p_gateZero) else $error("zero bit acted");
	property p_gateOff;
		(periphClk & ~periphGateState) == '0;
	endproperty
	a_gateOff: assert property (p_gateOff) else $error("clock on a closed gate");
	// System gates and output ready
	property p_sysSet;
		(sysSetWr && !sysClrWr)
			|=> ((sysClkState[SYS_W-1:0] & $past(wrData[SYS_W-1:0])) == $past(wrData[SYS_W-1:0]));
	endproperty
	a_sysSet: assert property (p_sysSet) else $error("sys set lost");
	property p_rdyOff;
		sysClrWr |=> ((pmStatus[ST_ORDY_LSB +: NUM_OUT] & $past(wrData[SYS_OUT_LSB +: NUM_OUT])) == '0);
	endproperty
	a_rdyOff: assert property (p_rdyOff) else $error("ready kept after disable");
	property p_rdyEn;
		(pmStatus[ST_ORDY_LSB +: NUM_OUT] & ~sysClkState[SYS_OUT_LSB +: NUM_OUT]) == '0;
	endproperty
	a_rdyEn: assert property (p_rdyEn) else $error("ready while off");
	// Oscillator, PLL and master sequencing
	property p_oscWait;
		(oscCtrlWr && wrData[OSC_EN_BIT]) |=> !pmStatus[ST_OSC_BIT] [*8];
	endproperty
	a_oscWait: assert property (p_oscWait) else $error("stable flag too early");
	property p_lockClr;
		pllCfgWr |-> s_lockDown;
	endproperty
	a_lockClr: assert property (p_lockClr) else $error("lock kept");
	property p_lockEn;
		pmStatus[ST_LOCK_BIT] |-> pllEnable;
	endproperty
	a_lockEn: assert property (p_lockEn) else $error("lock while PLL off");
	property p_pllOn;
		pllEnable == ((pllDivRatio != '0) && (pllFactor != '0));
	endproperty
	a_pllOn: assert property (p_pllOn) else $error("PLL enable mismatch");
	property p_mckClr;
		mckCfgWr |-> s_mckDown;
	endproperty
	a_mckClr: assert property (p_mckClr) else $error("master ready kept");
	// Interrupt level one cycle after flag and mask
	property p_irqOn;
		((pmStatus & irqMaskState) != '0) |=> irq;
	endproperty
	a_irqOn: assert property (p_irqOn) else $error("interrupt missing");
	property p_irqOff;
		((pmStatus & irqMaskState) == '0) |=> !irq;
	endproperty
	a_irqOff: assert property (p_irqOff) else $error("stray interrupt");
endmodule : cgo_clock_gating_props

bind cgo_clock_gating cgo_clock_gating_props u_cgo_clock_gating_props (
	.core_clk(core_clk), .rst_n(rst_n), .wrData(wrData), .periphSetWr(periphSetWr),
	.periphClrWr(periphClrWr), .sysSetWr(sysSetWr), .sysClrWr(sysClrWr),
	.oscCtrlWr(oscCtrlWr), .pllCfgWr(pllCfgWr), .mckCfgWr(mckCfgWr),
	.periphGateState(periphGateState), .sysClkState(sysClkState), .pmStatus(pmStatus),
	.irqMaskState(irqMaskState), .pllEnable(pllEnable), .pllDivRatio(pllDivRatio),
	.pllFactor(pllFactor), .periphClk(periphClk), .irq(irq)
);
`default_nettype wire

// ===== dv/cgo_clock_gating_tb.sv
// Self-checking bench of the clock gating block.
// Assumes foreign clocks made here at whole multiples of the core period.
`timescale 1ns/10ps
`default_nettype none
module cgo_clock_gating_tb
	import cgo_pkg::*;
;
	localparam int SLOW_P = 16;
	localparam int MAIN_P = 4;
	localparam int PLL_P  = 6;
	localparam logic [9:0] PSET = 10'h001, PCLR = 10'h002, SSET = 10'h004, SCLR = 10'h008,
		OCFG = 10'h010, OSC = 10'h020, PLL = 10'h040, MASTER_CLOCK = 10'h080, IEN = 10'h100, IDIS = 10'h200;
	localparam logic [1:0] OSRC [4] = '{SRC_SLOW, SRC_MAIN, SRC_PLL, SRC_MAIN};
	localparam logic [2:0] ORAT [4] = '{3'h1, 3'h0, 3'h2, 3'h7};
	localparam int         OPER [4] = '{2*SLOW_P, MAIN_P, 4*PLL_P, 64*MAIN_P};
	logic                  core_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  slowClkPin = 1'b0, mainClkPin = 1'b0, pllClkPin = 1'b0;
	logic [WORD_W-1:0]     wrData = '0;
	logic [9:0]            stb = '0;
	logic [OUT_SEL_W-1:0]  outCfgSel = '0;
	logic [WORD_W-1:0]     periphGateState, sysClkState, pmStatus, freqMeasure, irqMaskState;
	logic                  oscEnable, pllEnable, masterClk, cpuClk, usbClk, irq;
	logic [PLL_DIV_W-1:0]  pllDivRatio;
	logic [PLL_MUL_W-1:0]  pllFactor;
	logic [PERIPH_W-1:0]   periphClk;
	logic [NUM_OUT-1:0]    outclkPin;
	logic [20:0]           probes;
	int                    cyc = 0;
	int                    miscompares = 0;
	int                    numChecks = 0;
	int                    per;

	// Status bits at their own index, then clocks and the done flag
	assign probes = {freqMeasure[FREQ_DONE_BIT], cpuClk, masterClk, usbClk, periphClk[8],
		outclkPin, pmStatus[11:0]};

	always #25 core_clk = ~core_clk;
	// Foreign clocks, phases of two core cycles or more
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		slowClkPin <= (cyc % SLOW_P) < SLOW_P / 2;
		mainClkPin <= (cyc % MAIN_P) < MAIN_P / 2;
		pllClkPin <= (cyc % PLL_P) < PLL_P / 2;
	end

	cgo_clock_gating u_cgo_clock_gating (
		.core_clk(core_clk), .rst_n(rst_n), .slowClkPin(slowClkPin), .mainClkPin(mainClkPin),
		.pllClkPin(pllClkPin), .wrData(wrData), .periphSetWr(stb[0]), .periphClrWr(stb[1]),
		.sysSetWr(stb[2]), .sysClrWr(stb[3]), .outCfgWr(stb[4]), .outCfgSel(outCfgSel),
		.oscCtrlWr(stb[5]), .pllCfgWr(stb[6]), .mckCfgWr(stb[7]), .irqEnWr(stb[8]),
		.irqDisWr(stb[9]), .periphGateState(periphGateState), .sysClkState(sysClkState),
		.pmStatus(pmStatus), .freqMeasure(freqMeasure), .irqMaskState(irqMaskState),
		.oscEnable(oscEnable), .pllEnable(pllEnable), .pllDivRatio(pllDivRatio),
		.pllFactor(pllFactor), .periphClk(periphClk), .outclkPin(outclkPin),
		.masterClk(masterClk), .cpuClk(cpuClk), .usbClk(usbClk), .irq(irq)
	);

	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		numChecks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One write, then a dead cycle
	task automatic wr(input logic [9:0] which, input logic [WORD_W-1:0] d, input int sel = 0);
		@(posedge core_clk);
		stb <= which;
		wrData <= d;
		outCfgSel <= OUT_SEL_W'(sel);
		@(posedge core_clk);
		stb <= '0;
		@(negedge core_clk);
	endtask : wr

	task automatic waitHi(input int idx, input int lim);
		int k;
		k = 0;
		while (probes[idx] !== 1'b1 && k < lim)
		begin
			@(negedge core_clk);
			k++;
		end
	endtask : waitHi

	// Core cycles between two rising edges of a probe
	task automatic period(input int idx, output int p);
		logic prev;
		int   k;
		int   n;
		p = 0;
		n = 0;
		for (k = 0; k < 6000 && n < 2; k++)
		begin
			prev = probes[idx];
			@(negedge core_clk);
			p += (n == 1);
			n += (prev === 1'b0 && probes[idx] === 1'b1);
		end
	endtask : period

	task automatic test_done();
		$display("checks %0d miscompares %0d", numChecks, miscompares);
		if (miscompares == 0 && numChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done

	// Watchdog, far past the expected run
	initial
	begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		test_done();
	end

	initial
	begin
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		check(periphGateState | periphClk, 32'h0);
		check(sysClkState, 32'h1);
		check(pmStatus, 32'h8);
		check(freqMeasure | irqMaskState, 32'h0);
		wr(PSET, 32'h110);
		check(periphGateState, 32'h110);
		wr(PSET, 32'h0);
		check(periphGateState, 32'h110);
		wr(PCLR, 32'h10);
		check(periphGateState, 32'h100);
		check(32'(periphClk[4]), 32'h0);
		wr(PSET | PCLR, 32'h100);
		check(periphGateState, 32'h0);
		wr(PSET, 32'h100);
		period(16, per);
		check(32'(per), 32'(SLOW_P));
		$display("test gates done");
		wr(MASTER_CLOCK, {27'h0, 3'h4, SRC_MAIN});
		check(32'(pmStatus[ST_MRDY_BIT]), 32'h0);
		waitHi(ST_MRDY_BIT, 400);
		check(32'(pmStatus[ST_MRDY_BIT]), 32'h1);
		period(18, per);
		check(32'(per), 32'(16 * MAIN_P));
		period(19, per);
		check(32'(per), 32'(16 * MAIN_P));
		period(16, per);
		check(32'(per), 32'(16 * MAIN_P));
		$display("test master done");
		wr(IEN, 32'h1 << ST_OSC_BIT);
		wr(OSC, 32'h201);
		check(32'({oscEnable, pmStatus[ST_OSC_BIT]}), 32'h2);
		repeat (14 * SLOW_P) @(negedge core_clk);
		check(32'({irq, pmStatus[ST_OSC_BIT]}), 32'h0);
		waitHi(ST_OSC_BIT, 4 * SLOW_P);
		check(32'(pmStatus[ST_OSC_BIT]), 32'h1);
		repeat (2) @(negedge core_clk);
		check(32'(irq), 32'h1);
		wr(IDIS, 32'h1 << ST_OSC_BIT);
		@(negedge core_clk);
		check(32'(irq) | irqMaskState, 32'h0);
		waitHi(20, 20 * SLOW_P);
		check(freqMeasure, 32'h10000 | 32'(16 * SLOW_P / MAIN_P));
		$display("test oscillator done");
		wr(IEN, 32'h1 << ST_LOCK_BIT);
		wr(SSET, 32'h1 << SYS_USB_BIT);
		for (int r = 0; r < 3; r++)
		begin
			wr(PLL, 32'h00040501 | (32'(r) << PLL_USB_LSB));
			check(32'(pmStatus[ST_LOCK_BIT]), 32'h0);
			check(32'({pllEnable, pllDivRatio, pllFactor}), 32'({1'b1, 8'h01, 11'h004}));
			repeat (3 * SLOW_P) @(negedge core_clk);
			check(32'(pmStatus[ST_LOCK_BIT]), 32'h0);
			waitHi(ST_LOCK_BIT, 5 * SLOW_P);
			check(32'(pmStatus[ST_LOCK_BIT]), 32'h1);
			@(negedge core_clk);
			check(32'(irq), 32'h1);
			period(17, per);
			check(32'(per), 32'(PLL_P << r));
		end
		wr(PLL, 32'h00000501);
		check(32'({pllEnable, pllDivRatio, pllFactor}), 32'({1'b0, 8'h01, 11'h0}));
		repeat (8 * SLOW_P) @(negedge core_clk);
		check(32'(pmStatus[ST_LOCK_BIT]), 32'h0);
		wr(PLL, 32'h00040500);
		check(32'({pllEnable, pllDivRatio, pllFactor}), 32'({1'b0, 8'h00, 11'h004}));
		wr(PLL, 32'h00040501);
		waitHi(ST_LOCK_BIT, 8 * SLOW_P);
		wr(MASTER_CLOCK, {27'h0, 3'h1, SRC_PLL});
		waitHi(ST_MRDY_BIT, 400);
		period(18, per);
		check(32'(per), 32'(2 * PLL_P));
		wr(PLL, 32'h00040501);
		check(32'(pmStatus[ST_MRDY_BIT]), 32'h0);
		period(18, per);
		period(18, per);
		check(32'(per), 32'(2 * MAIN_P));
		waitHi(ST_MRDY_BIT, 8 * SLOW_P);
		check(32'(pmStatus[ST_MRDY_BIT:ST_LOCK_BIT]), 32'h3);
		$display("test pll done");
		wr(SSET, 32'h1 << SYS_OUT_LSB);
		check(sysClkState, 32'h181);
		waitHi(ST_ORDY_LSB, 400);
		period(12, per);
		check(32'(per), 32'(SLOW_P));
		wr(SCLR, 32'h1 << SYS_OUT_LSB);
		check(32'(pmStatus[ST_ORDY_LSB]), 32'h0);
		check(sysClkState, 32'h81);
		for (int i = 0; i < NUM_OUT; i++)
		begin
			wr(OCFG, {27'h0, ORAT[i], OSRC[i]}, i);
			wr(SSET, 32'h1 << (SYS_OUT_LSB + i));
			check(32'(sysClkState[SYS_OUT_LSB + i]), 32'h1);
			waitHi(ST_ORDY_LSB + i, 2200);
			check(32'(pmStatus[ST_ORDY_LSB + i]), 32'h1);
			period(12 + i, per);
			check(32'(per), 32'(OPER[i]));
			wr(OCFG, {27'h0, ORAT[i], OSRC[i]}, i);
			check(32'(pmStatus[ST_ORDY_LSB + i]), 32'h0);
			wr(SCLR, 32'h1 << (SYS_OUT_LSB + i));
			check(32'(sysClkState[SYS_OUT_LSB + i]), 32'h0);
		end
		$display("test outputs done");
		test_done();
	end
endmodule : cgo_clock_gating_tb
`default_nettype wire
